// ### src/mtk_pkg.sv
package mtk_pkg;
  localparam int CLK_PERIOD_NS = 8;
  localparam longint NS_PER_S = 64'd1000000000;
  localparam longint CLK_HZ = NS_PER_S / CLK_PERIOD_NS;

  localparam int DELAY_LONG_US = 33000;
  localparam int DELAY_SHORT_US = 10000;
  localparam int DELAY_CONST_LIMIT_US = 500;
  localparam int STREAM_LIMIT_S = 30;
  localparam int TONE_HZ = 900;
  localparam int TAIL_MS = 8;
  localparam int MS_US = 1000;

  localparam int DELAY_LONG_CYC = DELAY_LONG_US * 1000 / CLK_PERIOD_NS;
  localparam int DELAY_SHORT_CYC = DELAY_SHORT_US * 1000 / CLK_PERIOD_NS;
  // One cycle below the limit so the delay stays strictly shorter.
  localparam int DELAY_CONST_CYC = DELAY_CONST_LIMIT_US * 1000 / CLK_PERIOD_NS - 1;
  localparam longint STREAM_CYC = STREAM_LIMIT_S * NS_PER_S / CLK_PERIOD_NS;
  localparam int TONE_HALF_CYC = int'(CLK_HZ / (2 * TONE_HZ));
  localparam int MS_CYC = MS_US * 1000 / CLK_PERIOD_NS;
  localparam int TAIL_CYC = TAIL_MS * MS_CYC;

  localparam logic [11:0] REG_STATUS = 12'h000;
  localparam logic [11:0] REG_CONFIG = 12'h004;
  localparam logic [11:0] REG_IDLE = 12'h008;
  localparam logic [15:0] IDLE_MS_RESET = 16'h000a;

  localparam int SW_AUTO = 0;
  localparam int SW_DELAY = 1;
  localparam int SW_CARRIER = 2;
  localparam int SW_TAIL = 3;
  localparam int SW_GUARD = 4;
  localparam int SW_WIRING = 5;
  localparam int SW_TX_TERM = 6;
  localparam int SW_RX_TERM = 7;

  localparam int ST_CTS = 0;
  localparam int ST_CARRIER = 1;
  localparam int ST_TONE = 2;
  localparam int ST_LOCK = 3;
  localparam int ST_AUTO_RTS = 4;
  localparam int ST_TX_TERM = 5;
  localparam int ST_RX_EN = 6;
  localparam int ST_WAIT = 7;

  localparam int CF_PORT_RS232 = 8;
  localparam int CF_V23 = 9;
  localparam int CF_VALID = 10;

  typedef enum logic [2:0] {
    MTK_IDLE,
    MTK_TRAIN,
    MTK_SEND,
    MTK_TAIL,
    MTK_LOCK
  } mtk_state_t;
endpackage

// ### src/mtk_timer.sv
`timescale 1ns/1ns
`default_nettype none
module mtk_timer #(
  parameter int W = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clr,
  input wire logic en,
  input wire logic [W-1:0] limit,
  output logic done
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } mtk_tmr_t;

  mtk_tmr_t s;
  mtk_tmr_t next_s;

  // Done is a pure decode of the count so callers may use it in their
  // own next-state logic without forming a loop.
  assign done = (s.cnt >= limit);

  always_comb begin
    next_s = s;
    if (clr) begin
      next_s.cnt = '0;
    end else if (en && !done) begin
      next_s.cnt = s.cnt + {{(W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule
`default_nettype wire

// ### src/mtk_keying.sv
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module mtk_keying #(
  parameter int unsigned DELAY_LONG = mtk_pkg::DELAY_LONG_CYC,
  parameter int unsigned DELAY_SHORT = mtk_pkg::DELAY_SHORT_CYC,
  parameter int unsigned DELAY_CONST = mtk_pkg::DELAY_CONST_CYC,
  parameter int unsigned STREAM_LIMIT = 32'(mtk_pkg::STREAM_CYC),
  parameter int unsigned TONE_HALF = mtk_pkg::TONE_HALF_CYC,
  parameter int unsigned TAIL_LEN = mtk_pkg::TAIL_CYC,
  parameter int unsigned MS_LEN = mtk_pkg::MS_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] config_switch_bank,
  input wire logic host_port_select,
  input wire logic v23_mode_select,
  input wire logic rs232_rts,
  input wire logic rs232_txd,
  input wire logic rs485_txd,
  output logic rs232_enable,
  output logic rs485_enable,
  output logic cts,
  output logic line_txd,
  output logic carrier_on,
  output logic tail_tone,
  output logic tail_tone_active,
  output logic half_duplex,
  output logic rx_enable,
  output logic tx_term_600,
  output logic rx_term_600
);
  import mtk_pkg::*;

  if (DELAY_LONG == 0 || DELAY_SHORT == 0 || DELAY_CONST == 0) begin : g_chk_delay
    $error("Handshake delays must be at least one cycle.");
  end
  if (STREAM_LIMIT == 0 || TONE_HALF == 0 || TAIL_LEN == 0 || MS_LEN == 0) begin : g_chk_tmr
    $error("Timer lengths must be at least one cycle.");
  end
  // The guard must outlast the longest training, or no transfer could ever start.
  if (STREAM_LIMIT <= DELAY_LONG + 1) begin : g_chk_guard
    $error("Stream limit must exceed the longest handshake delay.");
  end
  // A tail shorter than one tone period would put no full tone cycle on the line.
  if (TAIL_LEN < 2 * TONE_HALF) begin : g_chk_tail
    $error("Tail must hold at least one full tone period.");
  end
  // Constant carrier exists to shorten the handshake, so its delay is the least.
  if (DELAY_CONST >= DELAY_SHORT || DELAY_SHORT > DELAY_LONG) begin : g_chk_order
    $error("Handshake delays must rise from constant to short to long.");
  end

  typedef struct packed {
    logic cfg_valid;
    logic [7:0] sw;
    logic port_rs232;
    logic v23;
    mtk_state_t st;
    logic auto_rts;
    logic prev_rts;
    logic line_txd;
    logic tone;
    logic [15:0] idle_cnt;
    logic [15:0] idle_limit;
    logic [31:0] prdata;
  } mtk_regs_t;

  mtk_regs_t s;
  mtk_regs_t next_s;

  logic host_rts;
  logic host_txd;
  logic rts_eff;
  logic const_carrier;
  logic dly_done;
  logic stream_done;
  logic tail_done;
  logic tone_done;
  logic ms_done;
  logic [31:0] dly_limit;
  logic in_tx;
  logic [31:0] status_word;
  logic [31:0] config_word;
  logic unmapped;

  // The RS-485 port carries no request line, so that host relies on the
  // automatic mode to raise a request.
  assign host_txd = s.port_rs232 ? rs232_txd : rs485_txd;
  assign host_rts = s.port_rs232 ? rs232_rts : 1'b0;
  assign rts_eff = s.sw[SW_AUTO] ? s.auto_rts : host_rts;
  assign const_carrier = s.sw[SW_CARRIER];
  assign in_tx = (s.st == MTK_TRAIN) || (s.st == MTK_SEND);

  always_comb begin
    if (const_carrier) begin
      dly_limit = DELAY_CONST;
    end else if (s.v23) begin
      dly_limit = DELAY_LONG;
    end else if (s.sw[SW_DELAY]) begin
      dly_limit = DELAY_LONG;
    end else begin
      dly_limit = DELAY_SHORT;
    end
  end

  mtk_timer #(.W(32)) u_dly (
    .pclk(pclk),
    .presetn(presetn),
    .clr(s.st != MTK_TRAIN),
    .en(s.st == MTK_TRAIN),
    .limit(dly_limit),
    .done(dly_done)
  );

  mtk_timer #(.W(32)) u_stream (
    .pclk(pclk),
    .presetn(presetn),
    .clr(!in_tx || !s.sw[SW_GUARD]),
    .en(in_tx),
    .limit(STREAM_LIMIT),
    .done(stream_done)
  );

  mtk_timer #(.W(32)) u_tail (
    .pclk(pclk),
    .presetn(presetn),
    .clr(s.st != MTK_TAIL),
    .en(s.st == MTK_TAIL),
    .limit(TAIL_LEN),
    .done(tail_done)
  );

  mtk_timer #(.W(32)) u_tone (
    .pclk(pclk),
    .presetn(presetn),
    .clr((s.st != MTK_TAIL) || tone_done),
    .en(s.st == MTK_TAIL),
    .limit(TONE_HALF - 32'd1),
    .done(tone_done)
  );

  // Millisecond tick for the idle timer; restarts on every space bit so
  // the idle interval is measured from the last activity.
  mtk_timer #(.W(32)) u_ms (
    .pclk(pclk),
    .presetn(presetn),
    .clr(ms_done || !host_txd || !s.auto_rts),
    .en(s.auto_rts),
    .limit(MS_LEN - 32'd1),
    .done(ms_done)
  );

  assign unmapped = (paddr != REG_STATUS) && (paddr != REG_CONFIG) && (paddr != REG_IDLE);

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[ST_CTS] = (s.st == MTK_SEND);
    status_word[ST_CARRIER] = carrier_on;
    status_word[ST_TONE] = (s.st == MTK_TAIL);
    status_word[ST_LOCK] = (s.st == MTK_LOCK);
    status_word[ST_AUTO_RTS] = s.auto_rts;
    status_word[ST_TX_TERM] = tx_term_600;
    status_word[ST_RX_EN] = rx_enable;
    status_word[ST_WAIT] = (s.st == MTK_TRAIN);
    config_word = 32'h0000_0000;
    config_word[7:0] = s.sw;
    config_word[CF_PORT_RS232] = s.port_rs232;
    config_word[CF_V23] = s.v23;
    config_word[CF_VALID] = s.cfg_valid;
  end

  always_comb begin
    next_s = s;
    next_s.prev_rts = rts_eff;

    // Straps are caught on the first edge after reset and never again.
    if (!s.cfg_valid) begin
      next_s.cfg_valid = 1'b1;
      next_s.sw = config_switch_bank;
      next_s.port_rs232 = !host_port_select;
      next_s.v23 = v23_mode_select;
    end

    // Space on the data line counts as activity; idle is mark.
    if (s.cfg_valid && s.sw[SW_AUTO]) begin
      if (!host_txd) begin
        next_s.auto_rts = 1'b1;
        next_s.idle_cnt = 16'h0000;
      end else if (s.auto_rts && ms_done) begin
        if (s.idle_cnt + 16'h0001 >= s.idle_limit) begin
          next_s.auto_rts = 1'b0;
          next_s.idle_cnt = 16'h0000;
        end else begin
          next_s.idle_cnt = s.idle_cnt + 16'h0001;
        end
      end
    end else begin
      next_s.auto_rts = 1'b0;
      next_s.idle_cnt = 16'h0000;
    end

    case (s.st)
      MTK_IDLE: begin
        if (s.cfg_valid && rts_eff) begin
          next_s.st = MTK_TRAIN;
        end
      end
      MTK_TRAIN: begin
        if (!rts_eff) begin
          next_s.st = MTK_IDLE;
        end else if (s.sw[SW_GUARD] && stream_done) begin
          next_s.st = MTK_LOCK;
        end else if (dly_done) begin
          next_s.st = MTK_SEND;
        end
      end
      MTK_SEND: begin
        if (s.sw[SW_GUARD] && stream_done) begin
          next_s.st = MTK_LOCK;
        end else if (!rts_eff) begin
          if (s.sw[SW_TAIL] && !s.v23 && !const_carrier) begin
            next_s.st = MTK_TAIL;
          end else begin
            next_s.st = MTK_IDLE;
          end
        end
      end
      MTK_TAIL: begin
        if (tail_done) begin
          next_s.st = MTK_IDLE;
        end else if (rts_eff) begin
          next_s.st = MTK_TRAIN;
        end
      end
      MTK_LOCK: begin
        if (s.prev_rts && !rts_eff) begin
          next_s.st = MTK_IDLE;
        end
      end
      default: begin
        next_s.st = MTK_IDLE;
      end
    endcase

    // Data reach the line only once clear-to-send is granted; mark otherwise.
    next_s.line_txd = (next_s.st == MTK_SEND) ? host_txd : 1'b1;

    if (s.st == MTK_TAIL) begin
      if (tone_done) begin
        next_s.tone = !s.tone;
      end
    end else begin
      next_s.tone = 1'b0;
    end

    if (psel && !penable) begin
      case (paddr)
        REG_STATUS: next_s.prdata = status_word;
        REG_CONFIG: next_s.prdata = config_word;
        REG_IDLE: next_s.prdata = {16'h0000, s.idle_limit};
        default: next_s.prdata = 32'h0000_0000;
      endcase
    end
    if (psel && penable && pwrite && (paddr == REG_IDLE)) begin
      // Zero would drop the request at once, so it is held at one.
      next_s.idle_limit = (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '{cfg_valid: 1'b0, sw: 8'h00, port_rs232: 1'b1, v23: 1'b0,
             st: MTK_IDLE, auto_rts: 1'b0, prev_rts: 1'b0, line_txd: 1'b1,
             tone: 1'b0, idle_cnt: 16'h0000,
             idle_limit: IDLE_MS_RESET, prdata: 32'h0000_0000};
    end else begin
      s <= next_s;
    end
  end

  assign pready = 1'b1;
  assign pslverr = psel && penable && unmapped;
  assign prdata = s.prdata;

  assign rs232_enable = s.cfg_valid && s.port_rs232;
  assign rs485_enable = s.cfg_valid && !s.port_rs232;
  assign cts = (s.st == MTK_SEND);
  assign line_txd = s.line_txd;
  // A lockout silences even a constant carrier until the host lets go.
  assign carrier_on = s.cfg_valid && (const_carrier ? (s.st != MTK_LOCK)
                      : (in_tx || (s.st == MTK_TAIL)));
  assign tail_tone = s.tone;
  assign tail_tone_active = (s.st == MTK_TAIL);
  assign half_duplex = s.sw[SW_WIRING];
  assign rx_enable = s.cfg_valid && !(s.sw[SW_WIRING] && carrier_on);
  assign tx_term_600 = s.sw[SW_TX_TERM] ? (rts_eff && s.st != MTK_LOCK) : 1'b1;
  assign rx_term_600 = s.sw[SW_RX_TERM];
endmodule
`default_nettype wire

// ### test/mtk_keying_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module mtk_keying_asserts #(
  parameter int unsigned DELAY_LONG = 40,
  parameter int unsigned DELAY_SHORT = 12,
  parameter int unsigned DELAY_CONST = 4,
  parameter int unsigned STREAM_LIMIT = 200
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] config_switch_bank,
  input wire logic host_port_select,
  input wire logic v23_mode_select,
  input wire logic rs232_rts,
  input wire logic rs232_txd,
  input wire logic rs232_enable,
  input wire logic rs485_enable,
  input wire logic cts,
  input wire logic line_txd,
  input wire logic carrier_on,
  input wire logic tail_tone_active,
  input wire logic half_duplex,
  input wire logic rx_enable,
  input wire logic tx_term_600,
  input wire logic rx_term_600
);
  // Switches are latched here too, so edits made while running do not upset the checks.
  logic [7:0] cfg;
  logic first;
  logic lk;
  logic p_cts;
  logic p_rts;
  logic [31:0] wcnt;
  logic [31:0] ccnt;
  logic [31:0] lim;
  wire logic cap;
  assign cap = rs232_enable || rs485_enable;
  assign lim = cfg[2] ? DELAY_CONST : (v23_mode_select || cfg[1]) ? DELAY_LONG : DELAY_SHORT;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first <= 1'h1;
      cfg <= 8'h00;
      lk <= 1'h0;
      p_cts <= 1'h0;
      p_rts <= 1'h0;
      wcnt <= 32'h0;
      ccnt <= 32'h0;
    end else begin
      first <= 1'h0;
      cfg <= first ? config_switch_bank : cfg;
      p_cts <= cts;
      p_rts <= rs232_rts;
      lk <= rs232_rts && (lk || (p_cts && !cts && p_rts));
      wcnt <= (rs232_rts && !cts) ? wcnt + 32'h1 : 32'h0;
      ccnt <= cts ? ccnt + 32'h1 : 32'h0;
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_cts_delay: assert property ($rose(cts) && cap && !cfg[0] |->
    wcnt > lim && wcnt <= lim + 3) else $error("cts delay wrong");
  a_cts_drop: assert property (cap && !cfg[0] && !rs232_rts |-> ##1 !cts)
    else $error("cts held after release");
  a_port_onehot: assert property ($past(presetn) |->
    rs485_enable == host_port_select && rs232_enable == !host_port_select)
    else $error("port enables wrong");
  a_line_terms: assert property (cap |-> rx_term_600 == cfg[7] && (cfg[6] || tx_term_600))
    else $error("termination wrong");
  a_tx_term_idle: assert property (cap && cfg[6] && !cfg[0] && !rs232_rts
    && !$past(rs232_rts) |-> !tx_term_600) else $error("termination while idle");
  a_duplex_mode: assert property (cap |-> half_duplex == cfg[5] &&
    rx_enable == !(cfg[5] && carrier_on)) else $error("duplex wrong");
  a_line_mark: assert property (!cts && !$past(cts) |-> line_txd)
    else $error("data before cts");
  a_line_follow: assert property (cts && $past(cts) && !host_port_select |->
    line_txd == $past(rs232_txd)) else $error("line data wrong");
  a_tail_mode: assert property (tail_tone_active |-> cfg[3] && !v23_mode_select && !cfg[2])
    else $error("tail tone in wrong mode");
  a_guard_cut: assert property (cfg[4] |-> ccnt <= STREAM_LIMIT - lim)
    else $error("stream not cut");
  a_lock_hold: assert property (lk |-> !cts && !carrier_on)
    else $error("resumed before release");
endmodule
bind mtk_keying mtk_keying_asserts #(.DELAY_LONG(DELAY_LONG), .DELAY_SHORT(DELAY_SHORT),
  .DELAY_CONST(DELAY_CONST), .STREAM_LIMIT(STREAM_LIMIT)) u_chk (.pclk, .presetn,
  .config_switch_bank, .host_port_select, .v23_mode_select, .rs232_rts, .rs232_txd,
  .rs232_enable, .rs485_enable, .cts, .line_txd, .carrier_on, .tail_tone_active,
  .half_duplex, .rx_enable, .tx_term_600, .rx_term_600);
`default_nettype wire

// ### test/mtk_host.sv
`timescale 1ns/1ns
`default_nettype none
module mtk_host (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic go,
  input wire logic auto_tx,
  input wire logic cts,
  output logic rts,
  output logic txd
);
  // Data toggles every cycle while cts is granted or in automatic mode, so a stale or shifted bit on the line is always visible.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rts <= 1'h0;
      txd <= 1'h1;
    end else begin
      rts <= go && !auto_tx;
      txd <= (go && (cts || auto_tx)) ? !txd : 1'h1;
    end
  end
endmodule
`default_nettype wire

// ### test/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import mtk_pkg::*;
  localparam int unsigned DL = 40, DS = 12, DC = 4, SL = 200, TL = 30, ML = 5, TH = 3;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic go = 1'h0, auto_tx = 1'h0, host_port_select = 1'h0, v23_mode_select = 1'h0;
  logic rs485_txd = 1'h1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [7:0] config_switch_bank = 8'h00;
  logic pready, pslverr, rs232_rts, rs232_txd, rs232_enable, rs485_enable, cts, line_txd;
  logic carrier_on, tail_tone, tail_tone_active, half_duplex, rx_enable, tx_term_600;
  logic rx_term_600;
  int errors = 0, total_checks = 0;
  mtk_keying #(.DELAY_LONG(DL), .DELAY_SHORT(DS), .DELAY_CONST(DC), .STREAM_LIMIT(SL),
    .TONE_HALF(TH), .TAIL_LEN(TL), .MS_LEN(ML)) uut (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .config_switch_bank,
    .host_port_select, .v23_mode_select, .rs232_rts, .rs232_txd, .rs485_txd, .rs232_enable,
    .rs485_enable, .cts, .line_txd, .carrier_on, .tail_tone, .tail_tone_active,
    .half_duplex, .rx_enable, .tx_term_600, .rx_term_600);
  mtk_host host (.pclk, .presetn, .go, .auto_tx, .cts, .rts(rs232_rts), .txd(rs232_txd));
  always #4 pclk = ~pclk;
  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic stop_hung;
    errors++;
    end_sim();
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
    int i;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'h1) break;
    end
    if (i == 16) stop_hung();
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  function automatic logic sg(input int k);
    return k == 0 ? cts : tail_tone_active;
  endfunction
  task automatic wt(input int k, input logic v, output int n);
    for (n = 0; n < 4000; n++) begin
      @(negedge pclk);
      if (sg(k) === v) break;
    end
    if (n == 4000) stop_hung();
  endtask
  // Switches only count at start-up, so every configuration costs a fresh reset.
  task automatic boot(input logic [7:0] s, input logic h, input logic v);
    @(posedge pclk);
    go <= 1'h0;
    auto_tx <= 1'h0;
    config_switch_bank <= s;
    host_port_select <= h;
    v23_mode_select <= v;
    presetn <= 1'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    repeat (2) @(posedge pclk);
  endtask
  task automatic keyed(input logic [7:0] s, input logic v, input int unsigned lim);
    int n;
    logic t;
    boot(s, 1'h0, v);
    go <= 1'h1;
    wt(0, 1'h1, n);
    chk("cts_delay", 1'h1, n > lim && n <= lim + 4);
    @(negedge pclk);
    t = rs232_txd;
    @(negedge pclk);
    chk("line_txd", t, line_txd);
    chk("carrier", 1'h1, carrier_on);
    chk("lines", {s[5], s[7], 1'h1, !s[5]},
      {half_duplex, rx_term_600, tx_term_600, rx_enable});
    @(posedge pclk);
    go <= 1'h0;
    repeat (4) @(negedge pclk);
    chk("release", {s[2], 1'h0, !s[6]}, {carrier_on, cts, tx_term_600});
  endtask
  initial begin
    #400000;
    stop_hung();
  end
  initial begin
    int n;
    int k;
    logic t;
    logic [31:0] r;
    logic e;
    boot(8'ha5, 1'h0, 1'h1);
    config_switch_bank <= 8'h00;
    apb(1'h1, REG_CONFIG, 32'h0, r, e);
    apb(1'h0, REG_CONFIG, 32'h0, r, e);
    chk("config", 32'h7a5, r);
    apb(1'h0, REG_STATUS, 32'h0, r, e);
    chk("status", 32'h22, r);
    apb(1'h0, REG_IDLE, 32'h0, r, e);
    chk("idle_reset", {16'h0, IDLE_MS_RESET}, r);
    apb(1'h1, REG_IDLE, 32'h0, r, e);
    apb(1'h0, REG_IDLE, 32'h0, r, e);
    chk("idle_min", 32'h1, r);
    apb(1'h0, 12'hffc, 32'h0, r, e);
    chk("unmapped", 1'h1, e);
    boot(8'h00, 1'h1, 1'h0);
    go <= 1'h1;
    repeat (30) @(negedge pclk);
    chk("port", 3'h2, {rs232_enable, rs485_enable, cts});
    keyed(8'h00, 1'h0, DS);
    keyed(8'h02, 1'h0, DL);
    keyed(8'h00, 1'h1, DL);
    keyed(8'h02, 1'h1, DL);
    keyed(8'h04, 1'h0, DC);
    keyed(8'he0, 1'h0, DS);
    keyed(8'h08, 1'h1, DL);
    boot(8'h08, 1'h0, 1'h0);
    go <= 1'h1;
    wt(0, 1'h1, n);
    @(posedge pclk);
    go <= 1'h0;
    wt(1, 1'h1, n);
    k = 0;
    t = tail_tone;
    repeat (6 * TH) begin
      @(negedge pclk);
      if (tail_tone !== t) k++;
      t = tail_tone;
    end
    chk("tone_edges", 6, k);
    wt(1, 1'h0, n);
    chk("tail_len", 1'h1, n + 6 * TH >= TL - 2 && n + 6 * TH <= TL + 2);
    boot(8'h10, 1'h0, 1'h0);
    go <= 1'h1;
    wt(0, 1'h1, n);
    wt(0, 1'h0, n);
    chk("stream_cut", 1'h1, n + DS >= SL - 6 && n + DS <= SL + 2);
    repeat (20) @(negedge pclk);
    chk("locked", 2'h0, {cts, carrier_on});
    @(posedge pclk);
    go <= 1'h0;
    repeat (3) @(posedge pclk);
    go <= 1'h1;
    wt(0, 1'h1, n);
    chk("relaunch", 1'h1, n > DS && n <= DS + 4);
    boot(8'h01, 1'h0, 1'h0);
    apb(1'h1, REG_IDLE, 32'h2, r, e);
    auto_tx <= 1'h1;
    go <= 1'h1;
    wt(0, 1'h1, n);
    chk("auto_cts", 1'h1, n > DS && n <= DS + 5);
    chk("host_rts", 1'h0, rs232_rts);
    @(posedge pclk);
    go <= 1'h0;
    wt(0, 1'h0, n);
    chk("auto_idle", 1'h1, n >= 2 * ML - 1 && n <= 3 * ML + 4);
    end_sim();
  end
endmodule
`default_nettype wire
